// ### design/rsr_defines.svh
// rsr_defines.svh: addresses, bit positions, reset values and counts
// of the reset source recorder; included by the package and the design.
`ifndef RSR_DEFINES_SVH
`define RSR_DEFINES_SVH

// ==========================================================
// register map
`define RSR_CAUSE_ADDR     20'hfffa8
`define RSR_ADDR_W         20

// ==========================================================
// cause flag positions
`define RSR_BIT_ILLOP      7
`define RSR_BIT_WDOG       4
`define RSR_BIT_PARITY     2
`define RSR_BIT_BADACC     1
`define RSR_BIT_LOWV       0
`define RSR_FLAGS_RST      8'h00

// ==========================================================
// processor state and opcodes
`define RSR_PSW_RST        8'h06
`define RSR_ILLEGAL_OPCODE 8'hff

// ==========================================================
// internal reset hold time
`define RSR_HOLD_NS        160
`define RSR_CLK_NS         10
`define RSR_HOLD_CYC       ((`RSR_HOLD_NS + `RSR_CLK_NS - 1) / `RSR_CLK_NS)

`endif

// ### design/rsr_pkg.sv
// rsr_pkg.sv: types of the reset source recorder.
// assumes rsr_defines.svh is on the include path.
`include "rsr_defines.svh"

package rsr_pkg;

   // ==========================================================
   // reset sequencer states, one-hot
   typedef enum logic [3:0] {
      RSR_ST_RUN  = 4'b0001,
      RSR_ST_POR  = 4'b0010,
      RSR_ST_EXT  = 4'b0100,
      RSR_ST_INT  = 4'b1000
   } rsr_state_t;

endpackage

// ### design/rsr_reset_source_recorder.sv
// rsr_reset_source_recorder.sv: reset cause register and reset state
// control for the processor.
// assumes all inputs synchronous to clk_sys_i; sys_rst_i is power-up.
`timescale 1ns/10ps
`include "rsr_defines.svh"

module rsr_reset_source_recorder #(
   parameter int unsigned HOLD_CYC = `RSR_HOLD_CYC
) (
   // clock and power-up reset
   input  wire logic                   clk_sys_i,
   input  wire logic                   sys_rst_i,
   // external reset pin and power-on comparators
   input  wire logic                   ext_reset_n_i,
   input  wire logic                   por_above_rise_i,
   input  wire logic                   por_below_fall_i,
   // internal reset sources
   input  wire logic                   exec_valid_i,
   input  wire logic [7:0]             exec_opcode_i,
   input  wire logic                   debug_emul_i,
   input  wire logic                   watchdog_req_i,
   input  wire logic                   parity_err_i,
   input  wire logic                   bad_access_req_i,
   input  wire logic                   low_voltage_req_i,
   // processor register access
   input  wire logic                   reg_rd_i,
   input  wire logic                   reg_byte_i,
   input  wire logic [`RSR_ADDR_W-1:0] reg_addr_i,
   output logic      [7:0]             reg_rdata_o,
   input  wire logic                   prd_wr_i,
   input  wire logic                   prd_wdata_i,
   input  wire logic                   psw_wr_i,
   input  wire logic [7:0]             psw_wdata_i,
   // processor state
   output logic                        chip_rst_o,
   output logic                        pc_undefined_o,
   output logic [7:0]                  psw_o,
   output logic                        parity_reset_disable_o,
   output logic [4:0]                  reset_cause_flags_o,
   // pull-up port pin
   output logic                        pullup_pin_o,
   output logic                        pullup_pin_oe_o,
   output logic                        pullup_pin_pu_o,
   // reset indicator port pin
   output logic                        rst_ind_pin_o,
   output logic                        rst_ind_pin_oe_o
);

   // ==========================================================
   // declarations
   rsr_pkg::rsr_state_t state_r;
   rsr_pkg::rsr_state_t state_nxt;
   logic [7:0]  flags_r;
   logic [7:0]  set_vec;
   logic        por_hold_r;
   logic        illop_req;
   logic        parity_req;
   logic        int_req;
   logic        cause_hit;
   logic        clr_rd;
   logic        hard_rst;
   logic        por_rst;
   logic [15:0] hold_cnt_r;
   logic        prd_r;
   logic [7:0]  psw_r;
   logic [7:0]  rdata_r;

   // how the pieces fit together:
   // - power-on hold and the pin form the hard reset, which wipes the flags
   // - the five internal sources set one flag each and start a timed reset
   // - a byte read of the cause register hands out the flags and clears them
   // - processor state that leaves reset at a fixed value is reloaded on the
   //   way into any reset, so it already stands in the first reset cycle
   // - stack, ram and general registers are left to the core on purpose
   // limitations:
   // - comparator outputs are taken as clean digital levels, no filtering
   // - the psw and disable write ports stand in for the core's own writes
   // - a request that arrives while a reset runs is dropped, not queued
   // trade-off: reloading from state_nxt lengthens the path through the
   //   sequencer but avoids a cycle of stale state inside reset

   // keep only the five cause bits, others read zero
   function automatic logic [7:0] cause_mask(input logic [7:0] v);
      logic [7:0] m;
      m = 8'h00;
      m[`RSR_BIT_ILLOP]  = v[`RSR_BIT_ILLOP];
      m[`RSR_BIT_WDOG]   = v[`RSR_BIT_WDOG];
      m[`RSR_BIT_PARITY] = v[`RSR_BIT_PARITY];
      m[`RSR_BIT_BADACC] = v[`RSR_BIT_BADACC];
      m[`RSR_BIT_LOWV]   = v[`RSR_BIT_LOWV];
      return m;
   endfunction

   // ==========================================================
   // internal reset requests
   // emulator-issued ff is a breakpoint, not a trap
   assign illop_req  = exec_valid_i && !debug_emul_i &&
                       (exec_opcode_i == `RSR_ILLEGAL_OPCODE);
   // parity errors reset only while not disabled
   assign parity_req = parity_err_i && !prd_r;
   assign int_req    = illop_req || watchdog_req_i || parity_req ||
                       bad_access_req_i || low_voltage_req_i;
   // the fall comparator acts at once, not a cycle late through the hold
   // register; otherwise the core would run one more cycle below the level
   assign por_rst    = por_hold_r || por_below_fall_i;
   // pin or comparator resets dominate internal ones
   // all five internal sources are equal; several at once set all their flags
   assign hard_rst   = !ext_reset_n_i || por_rst;

   // ==========================================================
   // power-on hold: set at power-up and on fall, freed above rise
   // the fall input wins over the rise input when both are high, so a
   // supply hovering between the two levels keeps the core in reset
   // hazard: the hold only drops on a rise report, never on its own
   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         por_hold_r <= 1'b1;
      end else if (por_below_fall_i) begin
         por_hold_r <= 1'b1;
      end else if (por_above_rise_i) begin
         por_hold_r <= 1'b0;
      end
   end

   // ==========================================================
   // reset sequencer
   // run: core executing; por: supply hold; ext: pin held low;
   // int: timed reset after an internal source fired
   // priority in every state: supply first, then pin, then internal
   // a pin reset that outlasts the supply hold goes on as a pin reset,
   // so the pull-up pin stays floating until the pin is released
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         rsr_pkg::RSR_ST_RUN: begin
            if (por_rst)
               state_nxt = rsr_pkg::RSR_ST_POR;
            else if (!ext_reset_n_i)
               state_nxt = rsr_pkg::RSR_ST_EXT;
            else if (int_req)
               state_nxt = rsr_pkg::RSR_ST_INT;
         end
         rsr_pkg::RSR_ST_POR: begin
            if (!por_rst)
               state_nxt = ext_reset_n_i ? rsr_pkg::RSR_ST_RUN
                                         : rsr_pkg::RSR_ST_EXT;
         end
         rsr_pkg::RSR_ST_EXT: begin
            if (por_rst)
               state_nxt = rsr_pkg::RSR_ST_POR;
            else if (ext_reset_n_i)
               state_nxt = rsr_pkg::RSR_ST_RUN;
         end
         rsr_pkg::RSR_ST_INT: begin
            if (por_rst)
               state_nxt = rsr_pkg::RSR_ST_POR;
            else if (!ext_reset_n_i)
               state_nxt = rsr_pkg::RSR_ST_EXT;
            else if (hold_cnt_r == 16'h0000)
               state_nxt = rsr_pkg::RSR_ST_RUN;
         end
         default: state_nxt = rsr_pkg::RSR_ST_POR;
      endcase
   end

   // state register; power-up lands in the supply hold state
   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_r <= rsr_pkg::RSR_ST_POR;
      end else begin
         state_r <= state_nxt;
      end
   end

   // internal reset length; loaded on each internal request taken in the run state
   // the internal reset lasts HOLD_CYC cycles: loaded with HOLD_CYC-1
   // on entry and left when the count reads zero
   // limitation: HOLD_CYC above 65536 does not fit the 16-bit counter
   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         hold_cnt_r <= 16'h0000;
      end else if (state_r == rsr_pkg::RSR_ST_RUN && int_req) begin
         hold_cnt_r <= 16'(HOLD_CYC - 1);
      end else if (hold_cnt_r != 16'h0000) begin
         hold_cnt_r <= hold_cnt_r - 16'h0001;
      end
   end

   // ==========================================================
   // cause flags
   // one set bit per source at its fixed position; the mask function
   // keeps the unused bits at zero whatever the set vector carries
   always_comb begin
      set_vec = 8'h00;
      set_vec[`RSR_BIT_ILLOP]  = illop_req;
      set_vec[`RSR_BIT_WDOG]   = watchdog_req_i;
      set_vec[`RSR_BIT_PARITY] = parity_req;
      set_vec[`RSR_BIT_BADACC] = bad_access_req_i;
      set_vec[`RSR_BIT_LOWV]   = low_voltage_req_i;
   end

   // only a byte read clears; a bit read leaves the flags alone
   assign cause_hit = reg_rd_i && (reg_addr_i == `RSR_CAUSE_ADDR);
   assign clr_rd    = cause_hit && reg_byte_i;

   // requests are only counted while the core is running
   // hard reset clears everything; internal resets only or-in their bit,
   // so causes from earlier unread resets are still there to be read
   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         flags_r <= `RSR_FLAGS_RST;
      end else if (hard_rst) begin
         flags_r <= `RSR_FLAGS_RST;
      end else if (state_r == rsr_pkg::RSR_ST_RUN) begin
         // set ored after clear so a same-cycle cause survives
         flags_r <= cause_mask((clr_rd ? 8'h00 : flags_r) |
                               set_vec);
      end
   end

   // read data captured at the access, old value before the clear
   // held until the next matching read, so the core may sample it late
   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rdata_r <= 8'h00;
      end else if (cause_hit) begin
         rdata_r <= cause_mask(flags_r);
      end
   end

   // ==========================================================
   // parity reset disable, cleared by any reset
   // cleared on the edge that enters reset, so the first reset cycle
   // already shows parity resets enabled again
   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         prd_r <= 1'b0;
      end else if (state_nxt != rsr_pkg::RSR_ST_RUN) begin
         prd_r <= 1'b0;
      end else if (prd_wr_i) begin
         prd_r <= prd_wdata_i;
      end
   end

   // program status word; stack, ram and gprs are deliberately absent
   // reloaded on entry into reset and through it; a core write during
   // reset is ignored except in the last reset cycle, where state_nxt is already run and the write is taken
   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         psw_r <= `RSR_PSW_RST;
      end else if (state_nxt != rsr_pkg::RSR_ST_RUN) begin
         psw_r <= `RSR_PSW_RST;
      end else if (psw_wr_i) begin
         psw_r <= psw_wdata_i;
      end
   end

   // ==========================================================
   // outputs
   // chip reset comes straight from the state register, glitch free
   // the program counter is the only state flagged undefined in reset
   assign chip_rst_o             = (state_r != rsr_pkg::RSR_ST_RUN);
   assign pc_undefined_o         = chip_rst_o;
   assign psw_o                  = psw_r;
   assign parity_reset_disable_o = prd_r;
   // packed view of the five flags, highest cause first
   assign reset_cause_flags_o    = {flags_r[`RSR_BIT_ILLOP],
                                    flags_r[`RSR_BIT_WDOG],
                                    flags_r[`RSR_BIT_PARITY],
                                    flags_r[`RSR_BIT_BADACC],
                                    flags_r[`RSR_BIT_LOWV]};
   assign reg_rdata_o            = rdata_r;

   // pull-up pin never driven in reset; pull-up only on soft resets
   // the port logic takes the pin over again once chip reset drops
   assign pullup_pin_o     = 1'b0;
   assign pullup_pin_oe_o  = 1'b0;
   assign pullup_pin_pu_o  = (state_r == rsr_pkg::RSR_ST_INT);

   // indicator pin low through every reset, released after
   assign rst_ind_pin_o    = 1'b0;
   assign rst_ind_pin_oe_o = chip_rst_o;

endmodule

// ### verification/rsr_src_model.sv
// rsr_src_model.sv: internal reset sources facing the recorder
// assumes fire_i is driven by the bench just after a rising edge
`timescale 1ns/10ps
`include "rsr_defines.svh"
module rsr_src_model (
   // clock, reset and command, one bit per cause flag
   input  wire logic       clk_sys_i,
   input  wire logic       sys_rst_i,
   input  wire logic [4:0] fire_i,
   // request lines
   output logic            exec_valid_o,
   output logic [7:0]      exec_opcode_o,
   output logic [3:0]      req_o
);
   // one-cycle pulses; the opcode keeps moving so no stale ff sits still
   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         exec_valid_o  <= 1'b0;
         exec_opcode_o <= 8'h00;
         req_o         <= 4'h0;
      end else begin
         exec_valid_o  <= fire_i[4];
         exec_opcode_o <= fire_i[4] ? `RSR_ILLEGAL_OPCODE : exec_opcode_o + 8'h01;
         req_o         <= fire_i[3:0];
      end
   end
endmodule

// ### verification/rsr_reset_source_recorder_sva.sv
// rsr_reset_source_recorder_sva.sv: port assertions of the recorder
// assumes sources fire one at a time and never during a pin reset
`timescale 1ns/10ps
`include "rsr_defines.svh"
module rsr_recorder_chk #(parameter int unsigned HOLD_CYC = 16) (
   // clock, resets and pins
   input wire logic                   clk_sys_i, sys_rst_i, ext_reset_n_i, por_above_rise_i, por_below_fall_i,
   // sources and register read
   input wire logic                   exec_valid_i, debug_emul_i, watchdog_req_i, parity_err_i, bad_access_req_i,
   input wire logic                   low_voltage_req_i, reg_rd_i, reg_byte_i,
   input wire logic [`RSR_ADDR_W-1:0] reg_addr_i,
   // outputs
   input wire logic [7:0]             reg_rdata_o, psw_o,
   input wire logic [4:0]             reset_cause_flags_o,
   input wire logic                   chip_rst_o, pc_undefined_o, parity_reset_disable_o, pullup_pin_oe_o,
   input wire logic                   pullup_pin_pu_o, rst_ind_pin_o, rst_ind_pin_oe_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);
   // run state, other sources quiet, clearing read
   wire        idle   = !chip_rst_o && ext_reset_n_i && !por_below_fall_i;
   wire        others = parity_err_i | bad_access_req_i | low_voltage_req_i;
   wire        clr_rd = reg_rd_i && reg_byte_i && reg_addr_i == `RSR_CAUSE_ADDR;
   logic [7:0] cnt_r;
   logic       int_r;
   // reset length counter; avoids a long repetition in the hold check
   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cnt_r <= 8'h00;
         int_r <= 1'b0;
      end else begin
         cnt_r <= chip_rst_o ? cnt_r + 8'h01 : 8'h00;
         int_r <= chip_rst_o & (int_r | $rose(chip_rst_o) & ext_reset_n_i & !por_below_fall_i);
      end
   end
   sequence s_wdog; idle && watchdog_req_i && !reg_rd_i && !others && !exec_valid_i; endsequence
   sequence s_wdog_set; chip_rst_o && reset_cause_flags_o == ($past(reset_cause_flags_o) | 5'h08); endsequence
   property p_wdog; s_wdog |=> s_wdog_set; endproperty
   property p_read; idle && clr_rd && !watchdog_req_i && !others && !exec_valid_i |=>
      reg_rdata_o == {$past(reset_cause_flags_o[4]), 2'b00, $past(reset_cause_flags_o[3]), 1'b0,
      $past(reset_cause_flags_o[2:0])} && reset_cause_flags_o == 5'h00; endproperty
   property p_race; idle && clr_rd && watchdog_req_i |=> reset_cause_flags_o[3]; endproperty
   property p_ext; !ext_reset_n_i |=> chip_rst_o && reset_cause_flags_o == 5'h00 && !pullup_pin_pu_o; endproperty
   property p_fall; por_below_fall_i |=> chip_rst_o && reset_cause_flags_o == 5'h00; endproperty
   property p_rise; !por_above_rise_i |=> chip_rst_o; endproperty
   property p_pins; rst_ind_pin_oe_o == chip_rst_o && !rst_ind_pin_o && pc_undefined_o == chip_rst_o; endproperty
   property p_pull; !pullup_pin_oe_o && (!pullup_pin_pu_o || chip_rst_o); endproperty
   property p_psw; $rose(chip_rst_o) && ext_reset_n_i && !por_below_fall_i |->
      psw_o == `RSR_PSW_RST && !parity_reset_disable_o && pullup_pin_pu_o; endproperty
   property p_dbg; idle && exec_valid_i && debug_emul_i && !watchdog_req_i && !others |=> !chip_rst_o; endproperty
   property p_hold; $fell(chip_rst_o) && int_r |-> cnt_r == HOLD_CYC; endproperty
   property p_mask; reg_rdata_o[6:5] == 2'b00 && !reg_rdata_o[3]; endproperty
   a_wdog: assert property (p_wdog) else $error("watchdog flag not set alone");
   a_read: assert property (p_read) else $error("clearing read wrong");
   a_race: assert property (p_race) else $error("set lost to read");
   a_ext: assert property (p_ext) else $error("pin reset wrong");
   a_fall: assert property (p_fall) else $error("fall reset missing");
   a_rise: assert property (p_rise) else $error("early power-on release");
   a_pins: assert property (p_pins) else $error("indicator pin wrong");
   a_pull: assert property (p_pull) else $error("pull-up pin wrong");
   a_psw: assert property (p_psw) else $error("reset state wrong");
   a_dbg: assert property (p_dbg) else $error("debug opcode trapped");
   a_hold: assert property (p_hold) else $error("internal reset length wrong");
   a_mask: assert property (p_mask) else $error("unused bits not zero");
endmodule

bind rsr_reset_source_recorder rsr_recorder_chk #(.HOLD_CYC(HOLD_CYC)) rsr_recorder_chk_i (.*);

// ### verification/rsr_reset_source_recorder_tb_top.sv
// rsr_reset_source_recorder_tb_top.sv: self-checking bench of the recorder
// assumes the source model and the checker are compiled before it
`timescale 1ns/10ps
`include "rsr_defines.svh"
module rsr_reset_source_recorder_tb_top;
   localparam int unsigned HC = 3; // short hold keeps the run brief
   logic       clk_sys_i = 1'b0, sys_rst_i = 1'b1, ext_reset_n_i = 1'b1, por_above_rise_i = 1'b0;
   logic       por_below_fall_i = 1'b0, debug_emul_i = 1'b0, reg_rd_i = 1'b0, reg_byte_i = 1'b1;
   logic       prd_wr_i = 1'b0, prd_wdata_i = 1'b0, psw_wr_i = 1'b0, exec_valid, chip_rst_o, pc_undefined_o;
   logic       parity_reset_disable_o, pullup_pin_o, pullup_pin_oe_o, pullup_pin_pu_o, rst_ind_pin_o;
   logic       rst_ind_pin_oe_o;
   logic [19:0] reg_addr_i = `RSR_CAUSE_ADDR;
   logic [7:0] psw_wdata_i = 8'h00, reg_rdata_o, psw_o, op;
   logic [4:0] fire = 5'h00, reset_cause_flags_o, ex;
   logic [3:0] req;
   int         num_errors = 0, n_tests = 0;

   rsr_reset_source_recorder #(.HOLD_CYC(HC)) rsr_reset_source_recorder_i (.*, .exec_valid_i(exec_valid),
      .exec_opcode_i(op), .watchdog_req_i(req[3]), .parity_err_i(req[2]), .bad_access_req_i(req[1]),
      .low_voltage_req_i(req[0]));
   rsr_src_model rsr_src_model_i (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .fire_i(fire),
      .exec_valid_o(exec_valid), .exec_opcode_o(op), .req_o(req));

   always #5 clk_sys_i = ~clk_sys_i;

   task automatic stop_test();
      if (num_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic tick(input int n = 1);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic [7:0] pack(input logic [4:0] f);
      return {f[4], 2'b00, f[3], 1'b0, f[2:0]};
   endfunction
   // bounded wait for the internal reset to run out, plus the spare cycle
   task automatic settle();
      for (int i = 0; i < 40 && chip_rst_o !== 1'b0; i++) tick();
      tick();
   endtask
   task automatic hit(input logic [4:0] f);
      fire = f;
      tick();
      fire = 5'h00;
      tick(2);
      settle();
   endtask
   // a trailing idle cycle keeps back-to-back reads from clashing
   task automatic rd(input logic [19:0] a, input logic b);
      reg_addr_i = a;
      reg_byte_i = b;
      reg_rd_i = 1'b1;
      tick();
      reg_rd_i = 1'b0;
      tick();
   endtask

   initial begin
      int k;
      fork
         begin
            #200us;
            num_errors++;
            stop_test();
         end
      join_none
      void'($urandom(43));
      tick(4);
      sys_rst_i = 1'b0;
      tick(5);
      chk(chip_rst_o, 1'b1);
      por_above_rise_i = 1'b1;
      tick(3);
      chk(reset_cause_flags_o, 5'h00);
      chk(psw_o, `RSR_PSW_RST);
      chk(parity_reset_disable_o, 1'b0);
      ex = 5'h00;
      // random sources accumulate until a random clearing read
      for (int i = 0; i < 14; i++) begin
         k = $urandom_range(4, 0);
         psw_wdata_i = 8'($urandom());
         psw_wr_i = 1'b1;
         tick();
         psw_wr_i = 1'b0;
         hit(5'h01 << k);
         ex[k] = 1'b1;
         chk(reset_cause_flags_o, ex);
         chk(psw_o, `RSR_PSW_RST);
         if ($urandom_range(2, 0) == 0) begin
            rd(`RSR_CAUSE_ADDR, 1'b1);
            chk(reg_rdata_o, pack(ex));
            ex = 5'h00;
            chk(reset_cause_flags_o, ex);
         end
      end
      // bit read, unmapped read and debug ff leave the flags alone
      hit(5'h08);
      ex[3] = 1'b1;
      rd(`RSR_CAUSE_ADDR, 1'b0);
      chk(reg_rdata_o, pack(ex));
      rd(`RSR_CAUSE_ADDR + 20'h00001, 1'b1);
      debug_emul_i = 1'b1;
      hit(5'h10);
      debug_emul_i = 1'b0;
      chk(reset_cause_flags_o, ex);
      // watchdog request in the very cycle of the clearing read
      fire = 5'h08;
      tick();
      fire = 5'h00;
      rd(`RSR_CAUSE_ADDR, 1'b1);
      chk(reg_rdata_o, pack(ex));
      chk(pullup_pin_pu_o, 1'b1);
      settle();
      chk(reset_cause_flags_o, 5'h08);
      // disabled parity reset, then a bad-access reset re-enables it
      prd_wdata_i = 1'b1;
      prd_wr_i = 1'b1;
      tick();
      prd_wr_i = 1'b0;
      hit(5'h04); // parity error with resets disabled, ram taken as initialised
      chk(reset_cause_flags_o, 5'h08);
      hit(5'h02);
      chk(parity_reset_disable_o, 1'b0);
      // pin reset, then supply fall, each clearing everything
      ext_reset_n_i = 1'b0;
      tick(3);
      chk(reset_cause_flags_o, 5'h00);
      chk(pullup_pin_pu_o, 1'b0);
      chk(rst_ind_pin_oe_o, 1'b1);
      chk(pullup_pin_oe_o, 1'b0);
      chk(pullup_pin_o, 1'b0);
      ext_reset_n_i = 1'b1;
      hit(5'h01);
      por_below_fall_i = 1'b1;
      tick(3);
      chk(chip_rst_o, 1'b1);
      chk(reset_cause_flags_o, 5'h00);
      por_below_fall_i = 1'b0;
      settle();
      chk(chip_rst_o, 1'b0);
      stop_test();
   end
endmodule
